//--- verilog/pcide_phy_ctrl.sv
module pcide_phy_ctrl #(
    parameter int MINWAIT_CYC = pcide_pkg::MINWAIT_CYC,
    parameter int HOLD_CYC = pcide_pkg::SILENT_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver status, from link pins
    input wire logic locRcvrOk,
    input wire logic remRcvrOk,
    input wire logic scrOk,
    input wire logic invalidSym,
    // MII
    input wire logic txEn,
    // Outputs
    output pcide_pkg::pcide_txmode_t txMode,
    output logic linkStatusOk,
    output logic irq
);
    initial begin
        // Minwait must fit the 24-bit timer; hold must end within 1 ms
        if (MINWAIT_CYC < 1 || MINWAIT_CYC >= (1 << 24) || HOLD_CYC < 1
            || HOLD_CYC > pcide_pkg::CLK_MHZ * 1000)
            $error("pcide_phy_ctrl: bad timer parameter");
    end

    // =====================================================
    // Input synchronisers
    logic [2:0] locS_r, remS_r, scrS_r, invS_r;
    logic locOk_r, remOk_r, scrOk_r, invSym_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            locS_r <= 3'h0;
            remS_r <= 3'h0;
            scrS_r <= 3'h0;
            invS_r <= 3'h0;
        end else begin
            locS_r <= {locS_r[1:0], locRcvrOk};
            remS_r <= {remS_r[1:0], remRcvrOk};
            scrS_r <= {scrS_r[1:0], scrOk};
            invS_r <= {invS_r[1:0], invalidSym};
        end
    end
    // A change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            locOk_r <= 1'b0;
            remOk_r <= 1'b0;
            scrOk_r <= 1'b0;
            invSym_r <= 1'b0;
        end else begin
            if (locS_r[1] == locS_r[2]) locOk_r <= locS_r[2];
            if (remS_r[1] == remS_r[2]) remOk_r <= remS_r[2];
            if (scrS_r[1] == scrS_r[2]) scrOk_r <= scrS_r[2];
            if (invS_r[1] == invS_r[2]) invSym_r <= invS_r[2];
        end
    end

    // =====================================================
    // Registers
    logic [2:0] ctrl_r;
    logic [3:0] event_r, mask_r, evSet;
    logic retrainReq;
    logic apbWr, apbRd;
    pcide_pkg::pcide_state_t state_r, state_nxt;
    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign retrainReq = apbWr && paddr == pcide_pkg::ADDR_CTRL
        && pwdata[pcide_pkg::CTRL_RETRAIN];

    // Control register; retrain bit is a self-clearing strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= pcide_pkg::CTRL_RESET;
        end else if (apbWr && paddr == pcide_pkg::ADDR_CTRL) begin
            ctrl_r <= {1'b0, pwdata[1:0]};
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mask_r <= pcide_pkg::EV_RESET;
        end else if (apbWr && paddr == pcide_pkg::ADDR_MASK) begin
            mask_r <= pwdata[3:0];
        end
    end

    // Sticky events, read clears; a new event wins over the clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            event_r <= pcide_pkg::EV_RESET;
        end else if (apbRd && paddr == pcide_pkg::ADDR_EVENT) begin
            event_r <= evSet;
        end else begin
            event_r <= event_r | evSet;
        end
    end
    assign irq = |(event_r & mask_r);

    // Read data unregistered in the access cycle is fine: pready is 1,
    // so prdata is combinational from flops
    always_comb begin
        unique case (paddr)
            pcide_pkg::ADDR_CTRL: prdata = {29'h0, ctrl_r};
            pcide_pkg::ADDR_STATUS: prdata = {23'h0, scrOk_r, linkStatusOk,
                locOk_r, remOk_r, txMode, state_r};
            pcide_pkg::ADDR_EVENT: prdata = {28'h0, event_r};
            pcide_pkg::ADDR_MASK: prdata = {28'h0, mask_r};
            default: prdata = 32'h0;
        endcase
    end

    // =====================================================
    // Timers
    logic [23:0] tmr_r;
    logic minwaitDone, holdDone;
    assign minwaitDone = tmr_r >= 24'(MINWAIT_CYC - 1);
    assign holdDone = tmr_r >= 24'(HOLD_CYC - 1);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tmr_r <= 24'h0;
        end else if (state_nxt != state_r) begin
            tmr_r <= 24'h0;
        end else if (state_r == pcide_pkg::ST_WAIT && !locOk_r) begin
            tmr_r <= 24'h0; // OK must hold unbroken
        end else if (tmr_r != 24'hffffff) begin
            tmr_r <= tmr_r + 24'h1;
        end
    end

    // =====================================================
    // Control state machine
    logic restart;
    assign restart = retrainReq || invSym_r;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pcide_pkg::ST_SILENT: begin
                // Master starts at once; slave waits for OK idle
                if (ctrl_r[pcide_pkg::CTRL_ENABLE]
                    && (ctrl_r[pcide_pkg::CTRL_MASTER] || locOk_r))
                    state_nxt = pcide_pkg::ST_TRAIN;
            end
            pcide_pkg::ST_TRAIN: begin
                if (locOk_r) state_nxt = pcide_pkg::ST_WAIT;
            end
            pcide_pkg::ST_WAIT: begin
                if (restart) state_nxt = pcide_pkg::ST_TRAIN;
                else if (locOk_r && minwaitDone)
                    state_nxt = pcide_pkg::ST_DATA;
            end
            pcide_pkg::ST_DATA: begin
                if (restart) state_nxt = pcide_pkg::ST_TRAIN;
                else if (!locOk_r && !txEn)
                    state_nxt = pcide_pkg::ST_HOLD;
                else if (!remOk_r)
                    state_nxt = pcide_pkg::ST_IDLE;
            end
            pcide_pkg::ST_IDLE: begin
                if (restart) state_nxt = pcide_pkg::ST_TRAIN;
                else if (!locOk_r) state_nxt = pcide_pkg::ST_HOLD;
                else if (remOk_r) state_nxt = pcide_pkg::ST_DATA;
            end
            pcide_pkg::ST_HOLD: begin
                if (holdDone) state_nxt = pcide_pkg::ST_SILENT;
            end
            default: state_nxt = pcide_pkg::ST_SILENT;
        endcase
        if (!ctrl_r[pcide_pkg::CTRL_ENABLE])
            state_nxt = pcide_pkg::ST_SILENT;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) state_r <= pcide_pkg::ST_SILENT;
        else state_r <= state_nxt;
    end

    // Transmit mode and link status from flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txMode <= pcide_pkg::TX_SEND_Z;
            linkStatusOk <= 1'b0;
        end else begin
            unique case (state_nxt)
                pcide_pkg::ST_SILENT: txMode <= pcide_pkg::TX_SEND_Z;
                pcide_pkg::ST_DATA: txMode <= pcide_pkg::TX_SEND_N;
                default: txMode <= pcide_pkg::TX_SEND_I;
            endcase
            linkStatusOk <= state_nxt == pcide_pkg::ST_DATA
                || state_nxt == pcide_pkg::ST_IDLE;
        end
    end

    // Events
    assign evSet = {
        restart && state_r != pcide_pkg::ST_TRAIN,
        state_nxt == pcide_pkg::ST_SILENT && state_r == pcide_pkg::ST_HOLD,
        state_nxt == pcide_pkg::ST_IDLE && state_r != pcide_pkg::ST_IDLE,
        state_nxt == pcide_pkg::ST_DATA && state_r == pcide_pkg::ST_WAIT};

    // =====================================================
    // Assertions
    property p_stay;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_DATA && (locOk_r || txEn) && !restart
            && remOk_r && ctrl_r[0] |=> state_r == pcide_pkg::ST_DATA;
    endproperty
    a_stay: assert property (p_stay) else $error("left data early");
    property p_silent;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_DATA && !locOk_r && !txEn && !restart
            && ctrl_r[0] |=> state_r == pcide_pkg::ST_HOLD;
    endproperty
    a_silent: assert property (p_silent) else $error("no hold");
    property p_idle;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_DATA && !remOk_r && txEn && !restart
            && ctrl_r[0] |=> state_r == pcide_pkg::ST_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("no idle");
    sequence s_hold;
        state_r == pcide_pkg::ST_HOLD && holdDone;
    endsequence
    property p_reach;
        @(posedge sys_clk) disable iff (!resetn)
        s_hold |=> state_r == pcide_pkg::ST_SILENT
            ##1 txMode == pcide_pkg::TX_SEND_Z || state_r != pcide_pkg::ST_SILENT;
    endproperty
    a_reach: assert property (p_reach) else $error("no silent");
    property p_txen;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_DATA && txEn && remOk_r && !restart
            && ctrl_r[0] |=> state_r == pcide_pkg::ST_DATA;
    endproperty
    a_txen: assert property (p_txen) else $error("txen ignored");
    property p_mode;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(state_r == pcide_pkg::ST_DATA) |-> txMode == pcide_pkg::TX_SEND_N;
    endproperty
    a_mode: assert property (p_mode) else $error("no SEND_N");
    property p_hold;
        @(posedge sys_clk) disable iff (!resetn)
        $rose(state_r == pcide_pkg::ST_HOLD) |-> tmr_r == 24'h0
            && txMode == pcide_pkg::TX_SEND_I;
    endproperty
    a_hold: assert property (p_hold) else $error("hold start");
    property p_link;
        @(posedge sys_clk) disable iff (!resetn)
        linkStatusOk |-> state_r == pcide_pkg::ST_DATA
            || state_r == pcide_pkg::ST_IDLE;
    endproperty
    a_link: assert property (p_link) else $error("early link");

    // =====================================================
    // Checker helpers
    // Independent count of hold cycles; the shared timer clears on
    // every state change, so it cannot vouch for its own length
    logic [23:0] holdCnt_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            holdCnt_r <= 24'h0;
        end else if (state_r == pcide_pkg::ST_HOLD) begin
            holdCnt_r <= holdCnt_r + 24'h1;
        end else begin
            holdCnt_r <= 24'h0;
        end
    end

    // Restart from wait, data or idle goes back to training
    property p_restart;
        @(posedge sys_clk) disable iff (!resetn)
        restart && ctrl_r[pcide_pkg::CTRL_ENABLE]
            && state_r inside {pcide_pkg::ST_WAIT, pcide_pkg::ST_DATA,
            pcide_pkg::ST_IDLE} |=> state_r == pcide_pkg::ST_TRAIN;
    endproperty
    a_restart: assert property (p_restart) else $error("no retrain");
    // Minwait served with OK held gives a valid link
    property p_minwait;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_WAIT && locOk_r && minwaitDone && !restart
            && ctrl_r[pcide_pkg::CTRL_ENABLE]
            |=> state_r == pcide_pkg::ST_DATA && linkStatusOk;
    endproperty
    a_minwait: assert property (p_minwait) else $error("no link");
    // No link before minwait has run out
    property p_early;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_WAIT && !minwaitDone
            |=> state_r != pcide_pkg::ST_DATA;
    endproperty
    a_early: assert property (p_early) else $error("minwait cut");
    // Slave leaves silence once OK idle is seen
    property p_slave;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_SILENT && ctrl_r[pcide_pkg::CTRL_ENABLE]
            && !ctrl_r[pcide_pkg::CTRL_MASTER] && locOk_r
            |=> state_r == pcide_pkg::ST_TRAIN
            && txMode == pcide_pkg::TX_SEND_I;
    endproperty
    a_slave: assert property (p_slave) else $error("slave stuck");
    // Late receiver drop while in send idle still reaches hold
    property p_late;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_IDLE && !locOk_r && !restart
            && ctrl_r[pcide_pkg::CTRL_ENABLE]
            |=> state_r == pcide_pkg::ST_HOLD;
    endproperty
    a_late: assert property (p_late) else $error("idle stuck");
    // Hold lasts its full minimum before going silent
    property p_holdMin;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_HOLD && holdDone
            && ctrl_r[pcide_pkg::CTRL_ENABLE]
            |=> holdCnt_r >= 24'(HOLD_CYC);
    endproperty
    a_holdMin: assert property (p_holdMin) else $error("hold short");
    // Hold never outlasts its bound, so silence comes in time
    property p_holdMax;
        @(posedge sys_clk) disable iff (!resetn)
        holdCnt_r <= 24'(HOLD_CYC);
    endproperty
    a_holdMax: assert property (p_holdMax) else $error("hold long");
    // Reaching silence from hold is flagged to software
    property p_evSil;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == pcide_pkg::ST_HOLD && state_nxt == pcide_pkg::ST_SILENT
            |=> event_r[pcide_pkg::EV_TO_SILENT];
    endproperty
    a_evSil: assert property (p_evSil) else $error("no silent event");
endmodule // pcide_phy_ctrl

//--- verilog/pcide_pkg.sv
package pcide_pkg;
    // =====================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    // =====================================================
    // Control fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_RETRAIN = 2;
    localparam int CTRL_WIDTH = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // =====================================================
    // Event bits
    localparam int EV_LINK_UP = 0;
    localparam int EV_TO_IDLE = 1;
    localparam int EV_TO_SILENT = 2;
    localparam int EV_RETRAIN = 3;
    localparam int EV_WIDTH = 4;
    localparam logic [3:0] EV_RESET = 4'h0;
    // =====================================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SILENT_HOLD_NS = 3240;
    localparam int SILENT_HOLD_CYC = (SILENT_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int MINWAIT_US = 1;
    localparam int MINWAIT_CYC = MINWAIT_US * CLK_MHZ;
    // =====================================================
    // Transmit modes
    typedef enum logic [1:0] {
        TX_SEND_Z = 2'h0,
        TX_SEND_I = 2'h1,
        TX_SEND_N = 2'h2
    } pcide_txmode_t;
    // Control states, Gray along silent->train->wait->data->idle
    typedef enum logic [2:0] {
        ST_SILENT = 3'h0,
        ST_TRAIN = 3'h1,
        ST_WAIT = 3'h3,
        ST_DATA = 3'h2,
        ST_IDLE = 3'h6,
        ST_HOLD = 3'h7
    } pcide_state_t;
endpackage : pcide_pkg

//--- sim/pcide_partner.sv
// =====================================================
// Link partner across the pair, seen as receiver status
module pcide_partner (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Scenario controls
    input wire logic sending,
    input wire logic wantOk,
    input wire logic badSym,
    // Status toward the device
    output logic locRcvrOk,
    output logic remRcvrOk,
    output logic scrOk,
    output logic invalidSym
);
    timeunit 1ns;
    timeprecision 100ps;
    // Remote status is decoded from the stream, so it goes stale on silence
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            locRcvrOk <= 1'b0;
            scrOk <= 1'b0;
            remRcvrOk <= 1'b0;
            invalidSym <= 1'b0;
        end else begin
            locRcvrOk <= sending;
            scrOk <= sending;
            invalidSym <= badSym;
            if (sending) begin
                remRcvrOk <= wantOk & scrOk;
            end
        end
    end
endmodule // pcide_partner

//--- sim/pcide_phy_ctrl_test.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module pcide_phy_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HOLD = 4;
    logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic txEn = 0, sending = 0, wantOk = 0, badSym = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, locRcvrOk, remRcvrOk, scrOk, invalidSym;
    logic linkStatusOk, irq;
    pcide_pkg::pcide_txmode_t txMode;
    int failures = 0, n_tests = 0;
    // =====================================================
    // Design and partner
    pcide_phy_ctrl #(.MINWAIT_CYC(8), .HOLD_CYC(HOLD)) dut_u (.sys_clk,
        .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .locRcvrOk, .remRcvrOk, .scrOk, .invalidSym, .txEn,
        .txMode, .linkStatusOk, .irq);
    pcide_partner partner_u (.sys_clk, .resetn, .sending, .wantOk, .badSym,
        .locRcvrOk, .remRcvrOk, .scrOk, .invalidSym);
    // Clock, 5 ns period
    always #2.5 sys_clk = ~sys_clk;
    // =====================================================
    // Bus and wait helpers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitMode(input pcide_pkg::pcide_txmode_t m, input int n,
                            output int c);
        c = 0;
        while (txMode !== m && c < n) begin
            @(posedge sys_clk);
            c++;
        end
    endtask
    task automatic pollState(input logic [2:0] s);
        for (int i = 0; i < 20; i++) begin
            apb(1'b0, pcide_pkg::ADDR_STATUS, 32'h0);
            if (rd[2:0] === s) break;
        end
    endtask
    // =====================================================
    // Scenarios
    task automatic link_up(input logic m);
        int c;
        apb(1'b1, pcide_pkg::ADDR_CTRL, {30'h0, m, 1'b1});
        sending <= 1'b1;
        wantOk <= 1'b1;
        `CHK("linkEarly", 1'b0, linkStatusOk)
        waitMode(pcide_pkg::TX_SEND_I, 100, c);
        `CHK("modeI", pcide_pkg::TX_SEND_I, txMode)
        waitMode(pcide_pkg::TX_SEND_N, 200, c);
        `CHK("modeN", pcide_pkg::TX_SEND_N, txMode)
        `CHK("minwait", 1'b1, c >= 8)
        `CHK("linkOk", 1'b1, linkStatusOk)
        apb(1'b0, pcide_pkg::ADDR_STATUS, 32'h0);
        `CHK("stData", 3'(pcide_pkg::ST_DATA), rd[2:0])
        apb(1'b0, pcide_pkg::ADDR_EVENT, 32'h0);
        `CHK("evUp", 1'b1, rd[pcide_pkg::EV_LINK_UP])
    endtask
    // Held TX_EN keeps the link; releasing it leads to silence
    task automatic t_hold(input logic m);
        int c;
        link_up(m);
        apb(1'b1, pcide_pkg::ADDR_MASK, 32'h1 << pcide_pkg::EV_TO_SILENT);
        txEn <= 1'b1;
        sending <= 1'b0;
        repeat (30) @(posedge sys_clk);
        apb(1'b0, pcide_pkg::ADDR_STATUS, 32'h0);
        `CHK("stKeep", 3'(pcide_pkg::ST_DATA), rd[2:0])
        `CHK("irqQuiet", 1'b0, irq)
        txEn <= 1'b0;
        waitMode(pcide_pkg::TX_SEND_I, 50, c);
        `CHK("holdI", pcide_pkg::TX_SEND_I, txMode)
        waitMode(pcide_pkg::TX_SEND_Z, 300, c);
        `CHK("modeZ", pcide_pkg::TX_SEND_Z, txMode)
        `CHK("holdLen", 1'b1, c >= HOLD)
        `CHK("irqSet", 1'b1, irq)
        apb(1'b0, pcide_pkg::ADDR_EVENT, 32'h0);
        `CHK("evSil", 1'b1, rd[pcide_pkg::EV_TO_SILENT])
        @(posedge sys_clk);
        `CHK("irqClr", 1'b0, irq)
        $display("test hold done");
    endtask
    // Remote receiver fault and recovery, then both restart causes
    task automatic t_remote(input logic m);
        int c;
        link_up(m);
        wantOk <= 1'b0;
        pollState(3'(pcide_pkg::ST_IDLE));
        `CHK("stIdle", 3'(pcide_pkg::ST_IDLE), rd[2:0])
        apb(1'b0, pcide_pkg::ADDR_EVENT, 32'h0);
        `CHK("evIdle", 1'b1, rd[pcide_pkg::EV_TO_IDLE])
        wantOk <= 1'b1;
        pollState(3'(pcide_pkg::ST_DATA));
        `CHK("stBack", 3'(pcide_pkg::ST_DATA), rd[2:0])
        apb(1'b1, pcide_pkg::ADDR_CTRL, {29'h0, 1'b1, m, 1'b1});
        apb(1'b0, pcide_pkg::ADDR_EVENT, 32'h0);
        `CHK("evMgmt", 1'b1, rd[pcide_pkg::EV_RETRAIN])
        waitMode(pcide_pkg::TX_SEND_N, 200, c);
        `CHK("retrained", pcide_pkg::TX_SEND_N, txMode)
        badSym <= 1'b1;
        repeat (8) @(posedge sys_clk);
        badSym <= 1'b0;
        apb(1'b0, pcide_pkg::ADDR_EVENT, 32'h0);
        `CHK("evSym", 1'b1, rd[pcide_pkg::EV_RETRAIN])
        waitMode(pcide_pkg::TX_SEND_N, 200, c);
        `CHK("relink", pcide_pkg::TX_SEND_N, txMode)
        wantOk <= 1'b0;
        pollState(3'(pcide_pkg::ST_IDLE));
        sending <= 1'b0;
        waitMode(pcide_pkg::TX_SEND_Z, 300, c);
        `CHK("idleToZ", pcide_pkg::TX_SEND_Z, txMode)
        $display("test remote done");
    endtask
    // =====================================================
    // Main sequence and verdict
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        apb(1'b0, pcide_pkg::ADDR_CTRL, 32'h0);
        `CHK("ctrlRst", 32'h0, rd)
        apb(1'b1, 8'h10, 32'hffffffff);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        for (int r = 1; r >= 0; r--) begin
            t_hold(1'(r));
            t_remote(1'(r));
        end
        test_done();
    end
    // Watchdog sized well above the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        test_done();
    end
endmodule // pcide_phy_ctrl_test
